// ===== design/lom_regs.sv
// Register bank steering the left and right line output mixers.
// Assumes a same-clock register port and analog status pins that arrive
// asynchronously and are therefore synchronised here.
//
// How it works
// - The reserved register at 0x4F reads zero; writes are ignored.
// - Bit 7 at 0x50 routes left second line input into left mixer.
// - Bit 7 at 0x51 routes left preamp output into left mixer.
// - Bit 7 at 0x52 routes left DAC output into left mixer.
// - Bit 7 at 0x53 routes right second line input into left mixer.
// - Bit 7 at 0x54 routes right preamp output into left mixer.
// - Bit 7 at 0x55 routes right DAC output into left mixer.
// - Bit 7 at 0x57 routes left second line input into right mixer.
// - Bit 7 at 0x58 routes left preamp output into right mixer.
// - Bit 7 at 0x59 routes left DAC output into right mixer.
// - Each path register holds a read-write seven-bit volume, reset zero.
// - Level bits 7:4 set 0 to 9 dB in 1 dB steps, reset zero.
// - Bit 3 of 0x56 unmutes the left output; reset muted.
// - Bit 2 of 0x56 is read-only zero.
// - Bit 1 of 0x56 reads one while gains are pending; resets one.
// - Bit 0 of 0x56 reads one when the left driver is powered.
`timescale 1ns/1ps

module lom_regs
  import lom_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [lom_pkg::LOM_ADDR_W-1:0] reg_addr,
  input wire logic [lom_pkg::LOM_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [lom_pkg::LOM_DATA_W-1:0] reg_rdata,
  // Analog status inputs, asynchronous
  input wire logic left_line_output_driver_powered,
  input wire logic left_gain_applied,
  // Left line output mixer controls
  output logic left_second_line_input_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_second_line_input_to_left_vol,
  output logic left_preamp_output_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_preamp_output_to_left_vol,
  output logic left_dac_primary_output_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_dac_primary_output_to_left_vol,
  output logic right_second_line_input_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] right_second_line_input_to_left_vol,
  output logic right_preamp_output_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] right_preamp_output_to_left_vol,
  output logic right_dac_primary_output_to_left_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] right_dac_primary_output_to_left_vol,
  // Right line output mixer controls
  output logic left_second_line_input_to_right_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_second_line_input_to_right_vol,
  output logic left_preamp_output_to_right_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_preamp_output_to_right_vol,
  output logic left_dac_primary_output_to_right_en,
  output logic [lom_pkg::LOM_VOL_W-1:0] left_dac_primary_output_to_right_vol,
  // Left line output driver controls
  output logic [lom_pkg::LOM_LEVEL_W-1:0] left_line_output_driver_level,
  output logic left_line_output_driver_unmute
);
  import lom_pkg::*;

  // ==========================================================
  // Address decode
  logic [LOM_PATH_COUNT-1:0] path_hit;
  wire level_hit = (reg_addr == LOM_LEFT_LINE_OUT_LEVEL_STATUS);
  wire level_write = reg_write && level_hit;
  logic [7:0] path_reg [LOM_PATH_COUNT];

  assign path_hit[0] = reg_addr == LOM_LEFT_LINE2_TO_LEFT_OUT_PATH;
  assign path_hit[1] = reg_addr == LOM_LEFT_PREAMP_TO_LEFT_OUT_PATH;
  assign path_hit[2] = reg_addr == LOM_LEFT_DAC_TO_LEFT_OUT_PATH;
  assign path_hit[3] = reg_addr == LOM_RIGHT_LINE2_TO_LEFT_OUT_PATH;
  assign path_hit[4] = reg_addr == LOM_RIGHT_PREAMP_TO_LEFT_OUT_PATH;
  assign path_hit[5] = reg_addr == LOM_RIGHT_DAC_TO_LEFT_OUT_PATH;
  assign path_hit[6] = reg_addr == LOM_LEFT_LINE2_TO_RIGHT_OUT_PATH;
  assign path_hit[7] = reg_addr == LOM_LEFT_PREAMP_TO_RIGHT_OUT_PATH;
  assign path_hit[8] = reg_addr == LOM_LEFT_DAC_TO_RIGHT_OUT_PATH;

  // ==========================================================
  // Path registers
  // The reserved address has no storage at all, so a stray write to it
  // cannot change what it reads.
  // A write replaces the routing enable and the volume together.
  logic [LOM_PATH_COUNT-1:0] path_write;
  assign path_write = path_hit & {LOM_PATH_COUNT{reg_write}};

  // Left second line input into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_line2_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[0]),
    .wdata(reg_wdata),
    .q(path_reg[0])
  );

  // Left preamp output into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_preamp_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[1]),
    .wdata(reg_wdata),
    .q(path_reg[1])
  );

  // Left DAC primary output into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_dac_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[2]),
    .wdata(reg_wdata),
    .q(path_reg[2])
  );

  // Right second line input into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_right_line2_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[3]),
    .wdata(reg_wdata),
    .q(path_reg[3])
  );

  // Right preamp output into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_right_preamp_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[4]),
    .wdata(reg_wdata),
    .q(path_reg[4])
  );

  // Right DAC primary output into the left mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_right_dac_to_left (
    .clock(clock),
    .rst(rst),
    .load(path_write[5]),
    .wdata(reg_wdata),
    .q(path_reg[5])
  );

  // Left second line input into the right mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_line2_to_right (
    .clock(clock),
    .rst(rst),
    .load(path_write[6]),
    .wdata(reg_wdata),
    .q(path_reg[6])
  );

  // Left preamp output into the right mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_preamp_to_right (
    .clock(clock),
    .rst(rst),
    .load(path_write[7]),
    .wdata(reg_wdata),
    .q(path_reg[7])
  );

  // Left DAC primary output into the right mixer.
  lom_path_reg #(
    .WIDTH(LOM_DATA_W),
    .RESET_VALUE(LOM_PATH_RESET)
  ) u_left_dac_to_right (
    .clock(clock),
    .rst(rst),
    .load(path_write[8]),
    .wdata(reg_wdata),
    .q(path_reg[8])
  );

  // ==========================================================
  // Level and mute
  // Reserved level codes are stored as written; software keeps them out.
  logic [LOM_LEVEL_W-1:0] level;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= LOM_LEVEL_RESET;
    end else if (level_write) begin
      level <= reg_wdata[LOM_LEVEL_LSB +: LOM_LEVEL_W];
    end
  end

  // Mute has its own flop so the driver starts silent whatever the level.
  logic unmute;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unmute <= LOM_UNMUTE_RESET;
    end else if (level_write) begin
      unmute <= reg_wdata[LOM_UNMUTE_BIT];
    end
  end

  // ==========================================================
  // Status synchronisers
  // Only the second stage of each pair is read; the first may be
  // metastable for part of a cycle.
  logic power_meta, power_sync;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_meta <= 1'b0;
      power_sync <= 1'b0;
    end else begin
      power_meta <= left_line_output_driver_powered;
      power_sync <= power_meta;
    end
  end

  logic done_meta, done_sync;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else begin
      done_meta <= left_gain_applied;
      done_sync <= done_meta;
    end
  end

  // ==========================================================
  // Gain pending flag
  // Only the paths feeding the left mixer and the level register count.
  // A write in the same cycle as completion wins, so no change is lost.
  wire left_gain_write = level_write ||
      (reg_write && (|path_hit[5:0]));
  logic pending;
  wire next_pending = left_gain_write ? 1'b1 :
      (done_sync ? 1'b0 : pending);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending <= LOM_PENDING_RESET;
    end else begin
      pending <= next_pending;
    end
  end

  // ==========================================================
  // Read path
  // A plain case keeps each path and reserved address next to the value that it returns.
  logic [7:0] path_rd;
  always_comb begin
    case (reg_addr)
      LOM_RESERVED_BEFORE_MIXER: begin
        path_rd = 8'h00;
      end
      LOM_LEFT_LINE2_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[0];
      end
      LOM_LEFT_PREAMP_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[1];
      end
      LOM_LEFT_DAC_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[2];
      end
      LOM_RIGHT_LINE2_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[3];
      end
      LOM_RIGHT_PREAMP_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[4];
      end
      LOM_RIGHT_DAC_TO_LEFT_OUT_PATH: begin
        path_rd = path_reg[5];
      end
      LOM_LEFT_LINE2_TO_RIGHT_OUT_PATH: begin
        path_rd = path_reg[6];
      end
      LOM_LEFT_PREAMP_TO_RIGHT_OUT_PATH: begin
        path_rd = path_reg[7];
      end
      LOM_LEFT_DAC_TO_RIGHT_OUT_PATH: begin
        path_rd = path_reg[8];
      end
      default: begin
        path_rd = 8'h00;
      end
    endcase
  end

  wire [7:0] level_rd = {level, unmute, 1'b0, pending, power_sync};
  // Reserved and unmapped addresses fall through to zero.
  wire [7:0] next_rdata = !reg_read ? 8'h00 :
      (level_hit ? level_rd : path_rd);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Mixer and driver outputs, straight from the registers
  assign left_second_line_input_to_left_en = path_reg[0][LOM_ROUTE_BIT];
  assign left_second_line_input_to_left_vol = path_reg[0][LOM_VOL_W-1:0];
  assign left_preamp_output_to_left_en = path_reg[1][LOM_ROUTE_BIT];
  assign left_preamp_output_to_left_vol = path_reg[1][LOM_VOL_W-1:0];
  assign left_dac_primary_output_to_left_en = path_reg[2][LOM_ROUTE_BIT];
  assign left_dac_primary_output_to_left_vol = path_reg[2][LOM_VOL_W-1:0];
  assign right_second_line_input_to_left_en = path_reg[3][LOM_ROUTE_BIT];
  assign right_second_line_input_to_left_vol = path_reg[3][LOM_VOL_W-1:0];
  assign right_preamp_output_to_left_en = path_reg[4][LOM_ROUTE_BIT];
  assign right_preamp_output_to_left_vol = path_reg[4][LOM_VOL_W-1:0];
  assign right_dac_primary_output_to_left_en = path_reg[5][LOM_ROUTE_BIT];
  assign right_dac_primary_output_to_left_vol = path_reg[5][LOM_VOL_W-1:0];
  assign left_second_line_input_to_right_en = path_reg[6][LOM_ROUTE_BIT];
  assign left_second_line_input_to_right_vol = path_reg[6][LOM_VOL_W-1:0];
  assign left_preamp_output_to_right_en = path_reg[7][LOM_ROUTE_BIT];
  assign left_preamp_output_to_right_vol = path_reg[7][LOM_VOL_W-1:0];
  assign left_dac_primary_output_to_right_en = path_reg[8][LOM_ROUTE_BIT];
  assign left_dac_primary_output_to_right_vol = path_reg[8][LOM_VOL_W-1:0];
  assign left_line_output_driver_level = level;
  assign left_line_output_driver_unmute = unmute;

endmodule // lom_regs

// ==========================================================
// One path register: a routing enable above a volume code.
// Every path register is built from this one module, so all of them
// share one reset value and one load rule.
module lom_path_reg
  import lom_pkg::*;
#(
  parameter int WIDTH = lom_pkg::LOM_DATA_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = lom_pkg::LOM_PATH_RESET
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Load strobe and data from the register port
  input wire logic load,
  input wire logic [WIDTH-1:0] wdata,
  // Stored value
  output logic [WIDTH-1:0] q
);
  import lom_pkg::*;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (load) begin
      q <= wdata;
    end
  end

endmodule // lom_path_reg

// ===== include/lom_pkg.sv
// Package for the line output mixer control register bank.
// Assumes a byte-wide register port with eight-bit addresses.
package lom_pkg;

  // ==========================================================
  // Bus widths
  localparam int LOM_ADDR_W = 8;
  localparam int LOM_DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] LOM_RESERVED_BEFORE_MIXER = 8'h4F;
  localparam logic [7:0] LOM_LEFT_LINE2_TO_LEFT_OUT_PATH = 8'h50;
  localparam logic [7:0] LOM_LEFT_PREAMP_TO_LEFT_OUT_PATH = 8'h51;
  localparam logic [7:0] LOM_LEFT_DAC_TO_LEFT_OUT_PATH = 8'h52;
  localparam logic [7:0] LOM_RIGHT_LINE2_TO_LEFT_OUT_PATH = 8'h53;
  localparam logic [7:0] LOM_RIGHT_PREAMP_TO_LEFT_OUT_PATH = 8'h54;
  localparam logic [7:0] LOM_RIGHT_DAC_TO_LEFT_OUT_PATH = 8'h55;
  localparam logic [7:0] LOM_LEFT_LINE_OUT_LEVEL_STATUS = 8'h56;
  localparam logic [7:0] LOM_LEFT_LINE2_TO_RIGHT_OUT_PATH = 8'h57;
  localparam logic [7:0] LOM_LEFT_PREAMP_TO_RIGHT_OUT_PATH = 8'h58;
  localparam logic [7:0] LOM_LEFT_DAC_TO_RIGHT_OUT_PATH = 8'h59;

  // ==========================================================
  // Path register layout
  localparam int LOM_PATH_COUNT = 9;
  localparam int LOM_ROUTE_BIT = 7;
  localparam int LOM_VOL_W = 7;
  localparam logic [7:0] LOM_PATH_RESET = 8'h00;

  // ==========================================================
  // Level and status register layout
  localparam int LOM_LEVEL_LSB = 4;
  localparam int LOM_LEVEL_W = 4;
  localparam int LOM_UNMUTE_BIT = 3;
  localparam int LOM_RSVD_BIT = 2;
  localparam int LOM_PENDING_BIT = 1;
  localparam int LOM_POWER_BIT = 0;
  localparam logic [3:0] LOM_LEVEL_RESET = 4'h0;
  localparam logic [3:0] LOM_LEVEL_MAX = 4'h9;
  localparam logic LOM_UNMUTE_RESET = 1'b0;
  localparam logic LOM_PENDING_RESET = 1'b1;

endpackage : lom_pkg

// ===== tb/line_out_mixer_control_regs_tb.sv
// Self-checking bench for the line output mixer register bank.
// Assumes lom_pkg, lom_regs and the bound checker are compiled with it.
`timescale 1ns/1ps

module line_out_mixer_control_regs_tb;
  import lom_pkg::*;
  logic clock, rst, reg_write, reg_read, pwr, done;
  logic [7:0] reg_addr, reg_wdata, d;
  wire logic [7:0] reg_rdata;
  wire logic [7:0] pp [9];
  wire logic [3:0] lvl;
  wire logic unm;
  int miscompares = 0;
  int comparisons = 0;
  lom_regs DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .left_line_output_driver_powered(pwr),
    .left_gain_applied(done),
    .left_second_line_input_to_left_en(pp[0][7]),
    .left_second_line_input_to_left_vol(pp[0][6:0]),
    .left_preamp_output_to_left_en(pp[1][7]),
    .left_preamp_output_to_left_vol(pp[1][6:0]),
    .left_dac_primary_output_to_left_en(pp[2][7]),
    .left_dac_primary_output_to_left_vol(pp[2][6:0]),
    .right_second_line_input_to_left_en(pp[3][7]),
    .right_second_line_input_to_left_vol(pp[3][6:0]),
    .right_preamp_output_to_left_en(pp[4][7]),
    .right_preamp_output_to_left_vol(pp[4][6:0]),
    .right_dac_primary_output_to_left_en(pp[5][7]),
    .right_dac_primary_output_to_left_vol(pp[5][6:0]),
    .left_second_line_input_to_right_en(pp[6][7]),
    .left_second_line_input_to_right_vol(pp[6][6:0]),
    .left_preamp_output_to_right_en(pp[7][7]),
    .left_preamp_output_to_right_vol(pp[7][6:0]),
    .left_dac_primary_output_to_right_en(pp[8][7]),
    .left_dac_primary_output_to_right_vol(pp[8][6:0]),
    .left_line_output_driver_level(lvl),
    .left_line_output_driver_unmute(unm));
  // ==========================================================
  // Bus and check tasks; each starts and ends on a clock edge.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
  endtask
  // The read lowers its strobe and leaves one idle cycle, since the data
  // only stand in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  function automatic logic [7:0] pa(int i);
    return (i < 6) ? 8'(8'h50 + i) : 8'(8'h51 + i);
  endfunction
  function automatic logic [7:0] pv(int i);
    return {~i[0], 7'(7'h7F - i)};
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 8'h4F; a <= 8'h59; a++) begin
      rd(8'(a));
      chk(d, (a == 8'h56) ? 8'h02 : 8'h00);
    end
    $display("t_reset done");
  endtask
  task automatic t_paths();
    wr(8'h4E, 8'hFF);
    wr(8'h60, 8'hFF);
    for (int i = 0; i < 9; i++) wr(pa(i), pv(i));
    for (int i = 0; i < 9; i++) begin
      rd(pa(i));
      chk(d, pv(i));
      chk(pp[i], pv(i));
    end
    rd(8'h4F);
    chk(d, 8'h00);
    rd(8'h60);
    chk(d, 8'h00);
    $display("t_paths done");
  endtask
  task automatic t_level();
    wr(8'h56, 8'h98);
    rd(8'h56);
    chk(d, 8'h9A);
    chk({3'h0, lvl, unm}, 8'h13);
    wr(8'h56, 8'h00);
    rd(8'h56);
    chk(d, 8'h02);
    $display("t_level done");
  endtask
  task automatic t_status();
    pwr <= 1'b1;
    done <= 1'b1;
    repeat (6) @(posedge clock);
    rd(8'h56);
    chk(d, 8'h01);
    wr(8'h57, 8'h11);
    rd(8'h56);
    chk(d, 8'h01);
    done <= 1'b0;
    pwr <= 1'b0;
    repeat (4) @(posedge clock);
    wr(8'h52, 8'h05);
    rd(8'h56);
    chk(d, 8'h02);
    $display("t_status done");
  endtask
  task automatic end_of_test();
    $display("%0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    {reg_write, reg_read, pwr, done} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_paths();
    t_level();
    t_status();
    end_of_test();
  end
  initial begin
    #5000;
    miscompares++;
    end_of_test();
  end
endmodule // line_out_mixer_control_regs_tb

// ===== tb/lom_regs_chk.sv
// Checker for the line output mixer register bank.
// Assumes it is bound to lom_regs and sees only the ports it names.
`timescale 1ns/1ps

module lom_regs_chk
  import lom_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock,
  input wire logic rst,
  input wire logic [lom_pkg::LOM_ADDR_W-1:0] reg_addr,
  input wire logic [lom_pkg::LOM_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [lom_pkg::LOM_DATA_W-1:0] reg_rdata,
  // Controls under watch
  input wire logic left_second_line_input_to_left_en,
  input wire logic [lom_pkg::LOM_VOL_W-1:0] left_second_line_input_to_left_vol,
  input wire logic [lom_pkg::LOM_LEVEL_W-1:0] left_line_output_driver_level,
  input wire logic left_line_output_driver_unmute
);
  // ==========================================================
  // Decode
  wire logic wr50 = reg_write && reg_addr == 8'h50;
  wire logic rd50 = reg_read && reg_addr == 8'h50;
  wire logic wr56 = reg_write && reg_addr == 8'h56;
  wire logic rd56 = reg_read && reg_addr == 8'h56;
  wire logic rd4f = reg_read && reg_addr == 8'h4F;
  wire logic [7:0] path = {left_second_line_input_to_left_en,
                           left_second_line_input_to_left_vol};
  wire logic [4:0] lvl = {left_line_output_driver_level,
                          left_line_output_driver_unmute};
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_rsvd_read_zero: assert property (rd4f |=> reg_rdata == 8'h00)
    else $error("reserved register read not zero");
  a_route_bit_write: assert property (wr50 |=> path[7] == $past(reg_wdata[7]))
    else $error("routing enable not taken from write");
  a_vol_write: assert property (wr50 |=> path[6:0] == $past(reg_wdata[6:0]))
    else $error("volume not taken from write");
  a_level_write: assert property (wr56 |=> lvl == $past(reg_wdata[7:3]))
    else $error("level or mute not taken from write");
  a_level_hold: assert property (!wr56 |=> $stable(lvl))
    else $error("level or mute changed without a write");
  a_bit2_zero: assert property (rd56 |=> reg_rdata[2] == 1'b0)
    else $error("reserved status bit not zero");
  a_read_level: assert property (rd56 |=> reg_rdata[7:3] == lvl)
    else $error("level readback differs from outputs");
  a_read_path: assert property (rd50 |=> reg_rdata == path)
    else $error("path readback differs from outputs");
  a_pending_set: assert property (wr56 ##1 rd56 |=> reg_rdata[1])
    else $error("pending not set after level write");
  c_path_rw: cover property (wr50 ##1 rd50);
  c_level_rw: cover property (wr56 ##1 rd56);
  c_powered: cover property (rd56 ##1 reg_rdata[0]);
endmodule // lom_regs_chk

bind lom_regs lom_regs_chk u_chk (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .left_second_line_input_to_left_en(left_second_line_input_to_left_en),
  .left_second_line_input_to_left_vol(left_second_line_input_to_left_vol),
  .left_line_output_driver_level(left_line_output_driver_level),
  .left_line_output_driver_unmute(left_line_output_driver_unmute)
);
